/* File: hw/spi_pin_pkg.sv */
package spi_pin_pkg;
    localparam int BYTE_W = 8;
    localparam int FIFO_DEPTH = 16;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [2:0] BIT_FIRST = 3'h0;

    typedef struct packed {
        logic [BYTE_W-1:0] data;
        logic is_last;
    } rx_word_type;

    typedef enum logic [1:0] {
        PWR_STANDBY,
        PWR_ACTIVE,
        PWR_WRITING
    } pwr_state_type;
endpackage

/* File: hw/byte_fifo.sv */
`timescale 1ns/10ps
module byte_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] count;
    } fifo_state_type;

    fifo_state_type state_ff;
    fifo_state_type nxt_state;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic pop;

    assign in_ready = (state_ff.count != (AW+1)'(DEPTH));
    assign out_valid = (state_ff.count != '0);
    assign out_data = mem[state_ff.rd];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        nxt_state = state_ff;
        if (push) begin
            nxt_state.wr = state_ff.wr + 1'b1;
        end
        if (pop) begin
            nxt_state.rd = state_ff.rd + 1'b1;
        end
        if (push && !pop) begin
            nxt_state.count = state_ff.count + 1'b1;
        end else if (pop && !push) begin
            nxt_state.count = state_ff.count - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[state_ff.wr] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end
endmodule

/* File: hw/spi_pin_front.sv */
// Notes on behaviour
// R1 - The serial output is push/pull and carries read data during a read.
// R2 - The output bit changes only after a falling serial clock edge.
// R3 - The host sends every opcode, address and write byte on the serial input.
// R4 - The serial input is captured on each rising serial clock edge while selected.
// R5 - Select high deselects the part and floats the serial output.
// R6 - Deselected means standby, unless a nonvolatile write is still running.
// R7 - Select low enables the part and puts it in active power mode.
// R8 - After power-up nothing is done until a select falling edge has been seen.
// R9 - Protect low blocks nonvolatile writes and leaves everything else working.
// R10 - Protect high lets every function including writes work normally.
// R11 - Protect going low while selected during a write aborts that write.
// R12 - Once the internal write has begun, protect falling does not stop it.
// R13 - All bytes move most significant bit first in both directions.
// R14 - The host holds select low for the whole operation.
// R15 - The serial clock may stop anywhere and shifting resumes where it left off.
// R16 - Clock and data are ignored while deselected; the bit count restarts on select fall.
`timescale 1ns/10ps
module spi_pin_front
    import spi_pin_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic select_and_kick_input_n,
    input wire logic serial_clock,
    input wire logic serial_in,
    input wire logic write_protect_n,
    output logic serial_out,
    output logic serial_out_oe,
    output logic [BYTE_W-1:0] rx_data,
    output logic rx_first,
    output logic rx_valid,
    input wire logic rx_ready,
    input wire logic [BYTE_W-1:0] tx_data,
    output logic tx_load,
    input wire logic read_active,
    input wire logic write_request,
    output logic write_start,
    input wire logic write_done,
    output logic write_aborted,
    output logic write_busy,
    output logic active_mode,
    output logic armed,
    output logic rx_overflow
);
    typedef struct packed {
        logic [1:0] cs_sync;
        logic [1:0] sck_sync;
        logic [1:0] si_sync;
        logic [1:0] wp_sync;
        logic cs_prev;
        logic sck_prev;
        logic wp_prev;
        logic armed;
        logic selected;
        logic [2:0] bit_cnt;
        logic [BYTE_W-1:0] rx_shift;
        logic [BYTE_W-1:0] tx_shift;
        logic first_byte;
        logic push;
        rx_word_type push_word;
        logic so;
        logic so_oe;
        logic tx_load;
        logic aborted;
        logic write_start;
        pwr_state_type pwr;
        logic overflow;
        logic busy;
        logic active;
    } front_state_type;

    front_state_type state_ff;
    front_state_type nxt_state;
    logic fifo_in_ready;
    logic fifo_out_valid;
    rx_word_type fifo_out;
    logic cs_n;
    logic sck;
    logic wp_n;
    logic cs_fall;
    logic sck_rise;
    logic sck_fall;
    logic wp_fall;

    assign cs_n = state_ff.cs_sync[1];
    assign sck = state_ff.sck_sync[1];
    assign wp_n = state_ff.wp_sync[1];
    assign cs_fall = state_ff.cs_prev && !cs_n;
    assign sck_rise = !state_ff.sck_prev && sck;
    assign sck_fall = state_ff.sck_prev && !sck;
    assign wp_fall = state_ff.wp_prev && !wp_n;

    always_comb begin
        nxt_state = state_ff;
        nxt_state.cs_sync = {state_ff.cs_sync[0], select_and_kick_input_n};
        nxt_state.sck_sync = {state_ff.sck_sync[0], serial_clock};
        nxt_state.si_sync = {state_ff.si_sync[0], serial_in};
        nxt_state.wp_sync = {state_ff.wp_sync[0], write_protect_n};
        nxt_state.cs_prev = cs_n;
        nxt_state.sck_prev = sck;
        nxt_state.wp_prev = wp_n;
        nxt_state.push = 1'b0;
        nxt_state.tx_load = 1'b0;
        nxt_state.write_start = 1'b0;
        if (cs_fall) begin
            nxt_state.armed = 1'b1; // [R8]
            nxt_state.selected = 1'b1; // [R7]
            nxt_state.bit_cnt = BIT_FIRST; // [R16]
            nxt_state.first_byte = 1'b1;
            nxt_state.aborted = 1'b0;
        end
        if (cs_n) begin
            nxt_state.selected = 1'b0; // [R16]
            nxt_state.so_oe = 1'b0; // [R5]
        end
        // Edges are acted on only from the sampled clock, so a stalled clock just waits
        if (state_ff.selected && state_ff.armed && !cs_n) begin // [R15]
            if (sck_rise) begin
                nxt_state.rx_shift = {state_ff.rx_shift[BYTE_W-2:0], state_ff.si_sync[1]}; // [R4] [R13]
                nxt_state.bit_cnt = state_ff.bit_cnt + 3'h1;
                if (state_ff.bit_cnt == BIT_LAST) begin
                    nxt_state.push = 1'b1;
                    nxt_state.push_word.data = {state_ff.rx_shift[BYTE_W-2:0], state_ff.si_sync[1]};
                    nxt_state.push_word.is_last = state_ff.first_byte;
                    nxt_state.first_byte = 1'b0;
                    nxt_state.tx_load = read_active;
                end
            end
            if (sck_fall && read_active) begin
                if (state_ff.bit_cnt == BIT_FIRST) begin
                    nxt_state.so = tx_data[BYTE_W-1]; // [R2] [R13]
                    nxt_state.tx_shift = {tx_data[BYTE_W-2:0], 1'b0};
                end else begin
                    nxt_state.so = state_ff.tx_shift[BYTE_W-1]; // [R2]
                    nxt_state.tx_shift = {state_ff.tx_shift[BYTE_W-2:0], 1'b0};
                end
                nxt_state.so_oe = 1'b1; // [R1]
            end
        end
        if (!cs_n && wp_fall && state_ff.pwr != PWR_WRITING) begin
            nxt_state.aborted = 1'b1; // [R11]
        end
        if (state_ff.push && !fifo_in_ready) begin
            nxt_state.overflow = 1'b1;
        end
        case (state_ff.pwr)
            PWR_STANDBY: begin
                if (!cs_n && state_ff.armed) begin
                    nxt_state.pwr = PWR_ACTIVE; // [R7]
                end
            end
            PWR_ACTIVE: begin
                // Write starts only at deselect, with protect high and no abort seen
                if (cs_n && write_request && wp_n && !state_ff.aborted) begin // [R9] [R10] [R11]
                    nxt_state.pwr = PWR_WRITING;
                    nxt_state.write_start = 1'b1;
                end else if (cs_n) begin
                    nxt_state.pwr = PWR_STANDBY; // [R6]
                end
            end
            PWR_WRITING: begin
                // Protect is not looked at here, the cycle always finishes
                if (write_done) begin // [R12]
                    nxt_state.pwr = cs_n ? PWR_STANDBY : PWR_ACTIVE; // [R6]
                end
            end
            default: begin
                nxt_state.pwr = PWR_STANDBY;
            end
        endcase
        // Registered copies so the status outputs leave straight from flops
        nxt_state.busy = (nxt_state.pwr == PWR_WRITING);
        nxt_state.active = (nxt_state.pwr != PWR_STANDBY);
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= '0;
            state_ff.cs_sync <= 2'h3;
            state_ff.cs_prev <= 1'b1;
            state_ff.wp_sync <= 2'h3;
            state_ff.wp_prev <= 1'b1;
            state_ff.pwr <= PWR_STANDBY;
        end else begin
            state_ff <= nxt_state;
        end
    end

    logic [BYTE_W-1:0] rx_data_ff;
    logic rx_first_ff;
    logic rx_valid_ff;
    logic fifo_pop;

    // Pop exactly when the output stage loads, else a stalled word is handed over twice
    assign fifo_pop = !rx_valid_ff || rx_ready;

    byte_fifo #(
        .WIDTH($bits(rx_word_type)),
        .DEPTH(DEPTH)
    ) u_rx_fifo (
        .clk(clk),
        .reset_n(reset_n),
        .in_data(state_ff.push_word),
        .in_valid(state_ff.push),
        .in_ready(fifo_in_ready),
        .out_data(fifo_out),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop)
    );

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_data_ff <= '0;
            rx_first_ff <= 1'b0;
            rx_valid_ff <= 1'b0;
        end else if (fifo_pop) begin
            rx_data_ff <= fifo_out.data;
            rx_first_ff <= fifo_out.is_last;
            rx_valid_ff <= fifo_out_valid;
        end
    end

    assign rx_data = rx_data_ff;
    assign rx_first = rx_first_ff;
    assign rx_valid = rx_valid_ff;
    assign serial_out = state_ff.so;
    assign serial_out_oe = state_ff.so_oe;
    assign tx_load = state_ff.tx_load;
    assign write_start = state_ff.write_start;
    assign write_aborted = state_ff.aborted;
    assign write_busy = state_ff.busy;
    assign active_mode = state_ff.active;
    assign armed = state_ff.armed;
    assign rx_overflow = state_ff.overflow;
endmodule

/* File: test/spi_pin_front_props.sv */
`timescale 1ns/10ps
module spi_pin_front_props
    import spi_pin_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic select_and_kick_input_n,
    input wire logic serial_clock,
    input wire logic write_protect_n,
    input wire logic serial_out,
    input wire logic serial_out_oe,
    input wire logic [BYTE_W-1:0] rx_data,
    input wire logic rx_valid,
    input wire logic rx_ready,
    input wire logic write_start,
    input wire logic write_done,
    input wire logic write_aborted,
    input wire logic write_busy,
    input wire logic active_mode,
    input wire logic armed
);
    logic sck_ff;
    logic [3:0] age_ff;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // Age saturates so long idle spans never wrap
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sck_ff <= 1'b0;
            age_ff <= 4'hF;
        end else begin
            sck_ff <= serial_clock;
            age_ff <= (sck_ff && !serial_clock) ? 4'h0 : ((age_ff == 4'hF) ? 4'hF : age_ff + 4'h1);
        end
    end
    a_oe_off_idle: assert property (select_and_kick_input_n [*6] |-> !serial_out_oe)
        else $error("output driven while deselected");
    a_out_after_fall: assert property ($past(serial_out_oe) && serial_out_oe && $changed(serial_out) |-> age_ff < 4'h8)
        else $error("output bit moved without a clock fall");
    a_active_on_sel: assert property ($fell(select_and_kick_input_n) |-> ##[1:6] active_mode)
        else $error("no active mode after select");
    a_idle_standby: assert property ((select_and_kick_input_n && !write_busy) [*6] |-> !active_mode)
        else $error("active while idle");
    a_arm_first: assert property (!armed |-> !rx_valid && !write_start)
        else $error("activity before arming");
    a_rx_hold: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
        else $error("byte dropped before taken");
    a_start_clean: assert property (write_start |-> !write_aborted && write_protect_n)
        else $error("write started after abort");
    a_protect_blocks: assert property (!write_protect_n [*8] |-> !write_start)
        else $error("write started while protected");
    a_busy_holds: assert property (write_busy && !write_done |=> write_busy)
        else $error("write cut short");
    a_start_busy: assert property (write_start |=> write_busy)
        else $error("start without busy");
    c_write: cover property (write_start);
    c_take: cover property (rx_valid && rx_ready);
    c_abort: cover property ($rose(write_aborted));
endmodule
bind spi_pin_front spi_pin_front_props props_u (.clk(clk), .reset_n(reset_n),
    .select_and_kick_input_n(select_and_kick_input_n), .serial_clock(serial_clock),
    .write_protect_n(write_protect_n), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready), .write_start(write_start),
    .write_done(write_done), .write_aborted(write_aborted), .write_busy(write_busy),
    .active_mode(active_mode), .armed(armed));

/* File: test/spi_host_model.sv */
`timescale 1ns/10ps
module spi_host_model (
    input wire logic clk,
    input wire logic miso,
    output logic cs_n,
    output logic sck,
    output logic mosi
);
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        mosi = 1'b0;
    end
    // Four clk a half period gives the 400 ns link
    task automatic half(input int extra);
        repeat (4 + extra) @(negedge clk);
    endtask
    task automatic select(input logic level);
        half(4);
        cs_n = level;
        mosi = ~mosi;
        half(4);
    endtask
    task automatic pulse_sck(input int n);
        repeat (n) begin
            half(0);
            sck = 1'b1;
            half(0);
            sck = 1'b0;
        end
    endtask
    // Sampled late in the high half, where the bit is surely settled
    task automatic xfer(input logic [7:0] tx, input int stall, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            mosi = tx[i];
            half(0);
            sck = 1'b1;
            half((i == 4) ? stall : 0);
            rx[i] = miso;
            sck = 1'b0;
        end
    endtask
endmodule

/* File: test/spi_pin_front_bench.sv */
`timescale 1ns/10ps
module spi_pin_front_bench;
    import spi_pin_pkg::*;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic wp_n, rx_ready, rd, wr_req, wr_done, miso_line;
    logic sel_n, sck, mosi, so, so_oe, rx_first, rx_valid, tx_load, w_start, w_abort, w_busy, act, armed, ovf;
    logic [BYTE_W-1:0] tx_data;
    int loads = 0;
    logic [BYTE_W-1:0] rx_data, got;
    int num_errors = 0;
    int tests_run = 0;
    always #25 clk = ~clk;
    // Released line reads inverted so a sample taken while floating shows up
    assign miso_line = so_oe ? so : ~so;
    always @(negedge clk) begin
        if (tx_load === 1'b1) begin
            loads++;
        end
    end
    spi_host_model host_u (.clk(clk), .miso(miso_line), .cs_n(sel_n), .sck(sck), .mosi(mosi));
    spi_pin_front dut_u (.clk(clk), .reset_n(reset_n), .select_and_kick_input_n(sel_n), .serial_clock(sck),
        .serial_in(mosi), .write_protect_n(wp_n), .serial_out(so), .serial_out_oe(so_oe), .rx_data(rx_data),
        .rx_first(rx_first), .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data), .tx_load(tx_load),
        .read_active(rd), .write_request(wr_req), .write_start(w_start), .write_done(wr_done),
        .write_aborted(w_abort), .write_busy(w_busy), .active_mode(act), .armed(armed), .rx_overflow(ovf));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test;
        $display("errors %0d, checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic pop(input logic [7:0] exp, input logic first);
        for (int n = 0; n < 300 && rx_valid !== 1'b1; n++) @(negedge clk);
        check(8'(rx_valid), 8'h01);
        check(rx_data, exp);
        check(8'(rx_first), 8'(first));
        rx_ready = 1'b1;
        @(negedge clk);
        rx_ready = 1'b0;
    endtask
    task automatic finish_write;
        wr_done = 1'b1;
        @(negedge clk);
        wr_done = 1'b0;
        repeat (3) @(negedge clk);
        check(8'(w_busy), 8'h00);
    endtask
    task automatic t_arm;
        host_u.pulse_sck(8);
        check(8'({armed, rx_valid}), 8'h00);
        host_u.select(1'b0);
        check(8'({armed, act}), 8'h03);
        host_u.select(1'b1);
        check(8'({act, so_oe}), 8'h00);
    endtask
    task automatic t_fill_write;
        wr_req = 1'b1;
        host_u.select(1'b0);
        for (int i = 0; i < 18; i++) host_u.xfer(8'h10 + 8'(i), 0, got);
        check(8'(ovf), 8'h01);
        host_u.select(1'b1);
        check(8'(w_busy), 8'h01);
        for (int i = 0; i < 17; i++) pop(8'h10 + 8'(i), i == 0);
        check(8'(rx_valid), 8'h00);
        finish_write;
    endtask
    task automatic t_protect;
        wp_n = 1'b0;
        host_u.select(1'b0);
        host_u.xfer(8'h5A, 0, got);
        host_u.select(1'b1);
        check(8'(w_busy), 8'h00);
        pop(8'h5A, 1'b1);
        wp_n = 1'b1;
        host_u.select(1'b0);
        host_u.xfer(8'h66, 0, got);
        wp_n = 1'b0;
        repeat (6) @(negedge clk);
        check(8'(w_abort), 8'h01);
        wp_n = 1'b1;
        host_u.select(1'b1);
        check(8'(w_busy), 8'h00);
        pop(8'h66, 1'b1);
        host_u.select(1'b0);
        host_u.xfer(8'h77, 0, got);
        host_u.select(1'b1);
        wp_n = 1'b0;
        repeat (20) @(negedge clk);
        check(8'(w_busy), 8'h01);
        finish_write;
        wp_n = 1'b1;
        wr_req = 1'b0;
        pop(8'h77, 1'b1);
    endtask
    task automatic t_read;
        int n0;
        n0 = loads;
        tx_data = 8'hC3;
        rd = 1'b1;
        host_u.select(1'b0);
        host_u.xfer(8'h03, 0, got);
        host_u.xfer(8'h00, 24, got);
        check(got, 8'hC3);
        tx_data = 8'h5A;
        host_u.xfer(8'h01, 0, got);
        check(got, 8'h5A);
        check(8'(so_oe), 8'h01);
        host_u.select(1'b1);
        rd = 1'b0;
        check(8'(loads - n0), 8'h03);
        pop(8'h03, 1'b1);
        pop(8'h00, 1'b0);
        pop(8'h01, 1'b0);
    endtask
    initial begin
        #2000000;
        num_errors++;
        stop_test;
    end
    initial begin
        wp_n = 1'b1;
        rx_ready = 1'b0;
        rd = 1'b0;
        wr_req = 1'b0;
        wr_done = 1'b0;
        tx_data = 8'h00;
        repeat (12) @(negedge clk);
        reset_n = 1'b1;
        repeat (3) @(negedge clk);
        t_arm;
        t_fill_write;
        t_protect;
        t_read;
        stop_test;
    end
endmodule
